//--- rtl/mmr_indirect_address_gen.sv
// Indirect operand address generator with mapped register byte check.
// Notes on behaviour
// [RL1] Auxiliary pre-add adds the constant to the pointer, stores it, then addresses with it.
// [RL2] Short-offset mode addresses high part : (start + pointer + 3-bit offset), pointer kept.
// [RL3] A short offset of zero is an illegal encoding and the operation is refused.
// [RL4] Plain coefficient mode addresses high part : (start + pointer), pointer kept.
// [RL5] Post-increment addresses with the pointer, then adds 1 for a word or 2 for a pair.
// [RL6] Post-decrement addresses with the pointer, then subtracts 1 or 2 likewise.
// [RL7] Base plus long offset adds a signed 16-bit offset to the address, pointer kept.
// [RL8] Coefficient pre-add updates the pointer by the long offset, then addresses with it.
// [RL9] A long-offset operation issued in parallel with another one is refused.
// [RL10] The second address of a pair is the first plus one if even, minus one if odd.
// [RL11] The first word of a pair goes to the named register, the second to the next one.
// [RL12] The full address is the high-part register above the 16-bit pointer sum.
// [RL13] No byte of a mapped register is ever accessed; byte forms reach data memory only.
// [RL14] A byte form that resolves to a mapped register raises the bus error request.
// [RL15] The byte check covers every byte load, shifted byte load and byte store form.
// [RL16] The buffer start is added only when the pointer is set circular in the config.
// [RL17] Low-part arithmetic wraps in 16 bits and never reaches the high part.
`timescale 1ns/10ps
module mmr_indirect_address_gen
  import mia_pkg::*;
#(
  parameter logic [22:0] MAPPED_TOP = MIA_MAPPED_TOP_DEFAULT
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic OP_VALID,
  input wire logic [2:0] OP_MODE,
  input wire logic [2:0] OP_AUX_SEL,
  input wire logic OP_DOUBLE,
  input wire logic OP_BYTE,
  input wire logic OP_PARALLEL,
  input wire logic [15:0] OP_LONG_OFFSET,
  input wire logic [2:0] OP_SHORT_OFFSET,
  input wire logic [4:0] OP_DEST,
  input wire logic [8:0] CIRC_CONFIG,
  input wire logic [15:0] AUX_BUFFER_START,
  input wire logic [15:0] COEF_BUFFER_START,
  input wire logic PTR_WR_EN,
  input wire logic [3:0] PTR_WR_SEL,
  input wire logic [15:0] PTR_WR_LOW,
  input wire logic [6:0] PTR_WR_HIGH,
  input wire logic [3:0] PTR_RD_SEL,
  output logic ADDR_VALID,
  output logic [22:0] ADDR_FIRST,
  output logic [22:0] ADDR_SECOND,
  output logic ADDR_DOUBLE,
  output logic [4:0] DEST_FIRST,
  output logic [4:0] DEST_SECOND,
  output logic BUS_ERROR_IRQ,
  output logic OP_REFUSED,
  output logic [15:0] PTR_RD_LOW,
  output logic [6:0] PTR_RD_HIGH
);

  if (MIA_AUX_COUNT != (1 << MIA_AUX_SEL_W))
  begin : g_bad_count
    $error("Auxiliary pointer count does not match its select width.");
  end

  typedef struct packed {
    logic [MIA_AUX_COUNT-1:0][MIA_LOW_W-1:0] aux_pointer;
    logic [MIA_AUX_COUNT-1:0][MIA_HIGH_W-1:0] aux_pointer_high;
    logic [MIA_LOW_W-1:0] coef_pointer;
    logic [MIA_HIGH_W-1:0] coef_pointer_high;
    logic addr_valid;
    logic [MIA_ADDR_W-1:0] addr_first;
    logic [MIA_ADDR_W-1:0] addr_second;
    logic addr_double;
    logic [MIA_DEST_W-1:0] dest_first;
    logic [MIA_DEST_W-1:0] dest_second;
    logic bus_error_irq;
    logic refused;
    logic [MIA_LOW_W-1:0] rd_low;
    logic [MIA_HIGH_W-1:0] rd_high;
  } mia_state_t;

  mia_state_t st_reg;
  mia_state_t st_next;

  // Long-offset modes carry their constant in an instruction extension.
  function automatic logic mia_uses_long(input logic [2:0] mode);
    mia_uses_long = (mode == MIA_AUX_PREADD) || (mode == MIA_COEF_PREADD) ||
                    (mode == MIA_COEF_BASE_LONG);
  endfunction : mia_uses_long

  function automatic logic mia_is_mapped(input logic [22:0] addr);
    mia_is_mapped = (addr <= MAPPED_TOP);
  endfunction : mia_is_mapped

  function automatic logic mia_is_coef(input logic [2:0] mode);
    mia_is_coef = (mode != MIA_AUX_PREADD) && (mode != MIA_AUX_SHORT);
  endfunction : mia_is_coef

  logic is_coef;
  logic [15:0] sel_ptr;
  logic [6:0] sel_high;
  logic [15:0] sel_start;
  logic sel_circ;
  logic [15:0] sel_offset;
  logic sel_use_offset;
  logic sel_preadd;
  mia_post_t sel_post;
  logic [22:0] calc_addr;
  logic [15:0] calc_ptr_next;
  logic [22:0] pair_addr;
  logic [4:0] pair_dest;

  assign is_coef = mia_is_coef(OP_MODE);
  assign sel_ptr = is_coef ? st_reg.coef_pointer :
                   st_reg.aux_pointer[OP_AUX_SEL];
  assign sel_high = is_coef ? st_reg.coef_pointer_high :
                    st_reg.aux_pointer_high[OP_AUX_SEL];
  assign sel_start = is_coef ? COEF_BUFFER_START : AUX_BUFFER_START;
  assign sel_circ = is_coef ? CIRC_CONFIG[MIA_CIRC_COEF_BIT] :
                    CIRC_CONFIG[OP_AUX_SEL]; // see [RL16]
  // The short offset is unsigned and is zero-extended.
  assign sel_offset = (OP_MODE == MIA_AUX_SHORT) ?
                      {13'h0000, OP_SHORT_OFFSET} : OP_LONG_OFFSET; // see [RL2]
  assign sel_use_offset = (OP_MODE == MIA_AUX_SHORT) ||
                          (OP_MODE == MIA_COEF_BASE_LONG); // see [RL7]
  assign sel_preadd = (OP_MODE == MIA_AUX_PREADD) ||
                      (OP_MODE == MIA_COEF_PREADD);
  assign sel_post = (OP_MODE == MIA_COEF_POSTINC) ? MIA_POST_INC :
                    (OP_MODE == MIA_COEF_POSTDEC) ? MIA_POST_DEC :
                    MIA_POST_NONE;

  mia_addr_calc u_calc (
    .ptr(sel_ptr),
    .ptr_high(sel_high),
    .buf_start(sel_start),
    .circular(sel_circ),
    .offset(sel_offset),
    .use_offset(sel_use_offset),
    .preadd(sel_preadd),
    .post(sel_post),
    .step_double(OP_DOUBLE),
    .addr(calc_addr),
    .ptr_next(calc_ptr_next)
  );

  mia_pair_addr u_pair (
    .first_addr(calc_addr),
    .first_dest(OP_DEST),
    .second_addr(pair_addr),
    .second_dest(pair_dest)
  );

  logic bad_encoding;
  logic bad_parallel;
  logic bad_byte_form;
  logic accept;
  logic byte_fault;

  assign bad_encoding = (OP_MODE == MIA_MODE_ILLEGAL) ||
                        ((OP_MODE == MIA_AUX_SHORT) &&
                         (OP_SHORT_OFFSET == MIA_SHORT_ZERO)); // see [RL3]
  assign bad_parallel = mia_uses_long(OP_MODE) && OP_PARALLEL; // see [RL9]
  // Byte forms exist only for single-word operands.
  assign bad_byte_form = OP_BYTE && OP_DOUBLE;
  assign accept = OP_VALID && !bad_encoding && !bad_parallel &&
                  !bad_byte_form;
  // One flag covers every byte load, shifted load and byte store form.
  assign byte_fault = accept && OP_BYTE &&
                      mia_is_mapped(calc_addr); // see [RL13] [RL15]

  always_comb
  begin
    st_next = st_reg;
    st_next.addr_valid = 1'b0;
    st_next.bus_error_irq = 1'b0;
    st_next.refused = OP_VALID && !accept;
    if (byte_fault)
    begin
      // The access is dropped and the pointer is left as it was.
      st_next.bus_error_irq = 1'b1; // see [RL14]
    end
    else if (accept)
    begin
      st_next.addr_valid = 1'b1;
      st_next.addr_first = calc_addr; // see [RL12]
      st_next.addr_second = OP_DOUBLE ? pair_addr : calc_addr; // see [RL10]
      st_next.addr_double = OP_DOUBLE;
      st_next.dest_first = OP_DEST; // see [RL11]
      st_next.dest_second = OP_DOUBLE ? pair_dest : OP_DEST; // see [RL11]
      if (is_coef)
        st_next.coef_pointer = calc_ptr_next; // see [RL5] [RL6] [RL8]
      else
        st_next.aux_pointer[OP_AUX_SEL] = calc_ptr_next; // see [RL1] [RL2]
    end
    // A direct pointer write from the core lands after the operation.
    if (PTR_WR_EN)
    begin
      if (PTR_WR_SEL == MIA_SEL_COEF)
      begin
        st_next.coef_pointer = PTR_WR_LOW;
        st_next.coef_pointer_high = PTR_WR_HIGH;
      end
      else if (PTR_WR_SEL < MIA_SEL_COEF)
      begin
        st_next.aux_pointer[PTR_WR_SEL[2:0]] = PTR_WR_LOW;
        st_next.aux_pointer_high[PTR_WR_SEL[2:0]] = PTR_WR_HIGH;
      end
    end
    if (PTR_RD_SEL == MIA_SEL_COEF)
    begin
      st_next.rd_low = st_reg.coef_pointer;
      st_next.rd_high = st_reg.coef_pointer_high;
    end
    else if (PTR_RD_SEL < MIA_SEL_COEF)
    begin
      st_next.rd_low = st_reg.aux_pointer[PTR_RD_SEL[2:0]];
      st_next.rd_high = st_reg.aux_pointer_high[PTR_RD_SEL[2:0]];
    end
    else
    begin
      st_next.rd_low = MIA_PTR_RESET;
      st_next.rd_high = MIA_HIGH_RESET;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_reg.aux_pointer <= '0;
      st_reg.aux_pointer_high <= '0;
      st_reg.coef_pointer <= MIA_PTR_RESET;
      st_reg.coef_pointer_high <= MIA_HIGH_RESET;
      st_reg.addr_valid <= 1'b0;
      st_reg.addr_first <= MIA_ADDR_RESET;
      st_reg.addr_second <= MIA_ADDR_RESET;
      st_reg.addr_double <= 1'b0;
      st_reg.dest_first <= MIA_DEST_RESET;
      st_reg.dest_second <= MIA_DEST_RESET;
      st_reg.bus_error_irq <= 1'b0;
      st_reg.refused <= 1'b0;
      st_reg.rd_low <= MIA_PTR_RESET;
      st_reg.rd_high <= MIA_HIGH_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign ADDR_VALID = st_reg.addr_valid;
  assign ADDR_FIRST = st_reg.addr_first;
  assign ADDR_SECOND = st_reg.addr_second;
  assign ADDR_DOUBLE = st_reg.addr_double;
  assign DEST_FIRST = st_reg.dest_first;
  assign DEST_SECOND = st_reg.dest_second;
  assign BUS_ERROR_IRQ = st_reg.bus_error_irq;
  assign OP_REFUSED = st_reg.refused;
  assign PTR_RD_LOW = st_reg.rd_low;
  assign PTR_RD_HIGH = st_reg.rd_high;

endmodule : mmr_indirect_address_gen

//--- rtl/mia_pkg.sv
// Shared constants and types of the indirect operand address generator.
package mia_pkg;

  localparam int MIA_LOW_W = 16;
  localparam int MIA_HIGH_W = 7;
  localparam int MIA_ADDR_W = 23;
  localparam int MIA_AUX_COUNT = 8;
  localparam int MIA_AUX_SEL_W = 3;
  localparam int MIA_PTR_SEL_W = 4;
  localparam int MIA_DEST_W = 5;
  localparam int MIA_SHORT_W = 3;
  localparam int MIA_CIRC_W = 9;

  // Position of the coefficient pointer bit in the circular config status.
  localparam int MIA_CIRC_COEF_BIT = 8;
  // Pointer select value of the coefficient pointer on the write port.
  localparam logic [3:0] MIA_SEL_COEF = 4'h8;

  localparam logic [15:0] MIA_PTR_RESET = 16'h0000;
  localparam logic [6:0] MIA_HIGH_RESET = 7'h00;
  localparam logic [22:0] MIA_ADDR_RESET = 23'h000000;
  localparam logic [4:0] MIA_DEST_RESET = 5'h00;

  localparam logic [15:0] MIA_STEP_WORD = 16'h0001;
  localparam logic [15:0] MIA_STEP_DBL = 16'h0002;
  localparam logic [22:0] MIA_PAIR_STEP = 23'h000001;
  localparam logic [4:0] MIA_DEST_STEP = 5'h01;
  localparam logic [2:0] MIA_SHORT_ZERO = 3'h0;

  // Highest address of the mapped register space, an arbitrary default.
  localparam logic [22:0] MIA_MAPPED_TOP_DEFAULT = 23'h00005F;

  typedef enum logic [2:0] {
    MIA_AUX_PREADD = 3'b000,
    MIA_AUX_SHORT = 3'b001,
    MIA_COEF_PLAIN = 3'b010,
    MIA_COEF_POSTINC = 3'b011,
    MIA_COEF_POSTDEC = 3'b100,
    MIA_COEF_BASE_LONG = 3'b101,
    MIA_COEF_PREADD = 3'b110,
    MIA_MODE_ILLEGAL = 3'b111
  } mia_mode_t;

  typedef enum logic [1:0] {
    MIA_POST_NONE = 2'b00,
    MIA_POST_INC = 2'b01,
    MIA_POST_DEC = 2'b10
  } mia_post_t;

endpackage : mia_pkg

//--- rtl/mia_addr_calc.sv
// Pointer arithmetic: effective address and updated pointer value.
`timescale 1ns/10ps
module mia_addr_calc
  import mia_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire logic [6:0] ptr_high,
  input wire logic [15:0] buf_start,
  input wire logic circular,
  input wire logic [15:0] offset,
  input wire logic use_offset,
  input wire logic preadd,
  input wire mia_post_t post,
  input wire logic step_double,
  output logic [22:0] addr,
  output logic [15:0] ptr_next
);

  logic [15:0] start_term;
  logic [15:0] off_term;
  logic [15:0] step;
  logic [15:0] updated;
  logic [15:0] addr_low;

  always_comb
  begin
    start_term = circular ? buf_start : MIA_PTR_RESET; // see [RL16]
    off_term = use_offset ? offset : MIA_PTR_RESET;
    step = step_double ? MIA_STEP_DBL : MIA_STEP_WORD;
    updated = ptr + offset; // see [RL1] [RL8]
    // All sums stay 16 bits wide so the high part is never touched.
    if (preadd)
    begin
      addr_low = start_term + updated; // see [RL1] [RL8] [RL17]
      ptr_next = updated;
    end
    else
    begin
      addr_low = start_term + ptr + off_term; // see [RL2] [RL4] [RL7] [RL17]
      unique case (post)
        MIA_POST_INC: ptr_next = ptr + step; // see [RL5] [RL17]
        MIA_POST_DEC: ptr_next = ptr - step; // see [RL6] [RL17]
        default: ptr_next = ptr;
      endcase
    end
    addr = {ptr_high, addr_low}; // see [RL12]
  end

endmodule : mia_addr_calc

//--- rtl/mia_pair_addr.sv
// Companion address and destination register of a double-word access.
`timescale 1ns/10ps
module mia_pair_addr
  import mia_pkg::*;
(
  input wire logic [22:0] first_addr,
  input wire logic [4:0] first_dest,
  output logic [22:0] second_addr,
  output logic [4:0] second_dest
);

  always_comb
  begin
    if (first_addr[0])
      second_addr = first_addr - MIA_PAIR_STEP; // see [RL10]
    else
      second_addr = first_addr + MIA_PAIR_STEP; // see [RL10]
    second_dest = first_dest + MIA_DEST_STEP; // see [RL11]
  end

endmodule : mia_pair_addr

//--- sim/mia_decoder_model.sv
// Decoder side model that supplies the selected aux buffer start.
`timescale 1ns/10ps
module mia_decoder_model
  import mia_pkg::*;
(
  input wire logic [2:0] aux_sel,
  output logic [15:0] aux_start
);
  assign aux_start = {1'h0, aux_sel, 12'h300};
endmodule : mia_decoder_model

//--- sim/mia_properties.sv
// Concurrent checks on the ports of the address generator.
`timescale 1ns/10ps
module mia_properties
  import mia_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic OP_VALID,
  input wire logic [2:0] OP_MODE,
  input wire logic OP_DOUBLE,
  input wire logic OP_BYTE,
  input wire logic OP_PARALLEL,
  input wire logic [2:0] OP_SHORT_OFFSET,
  input wire logic PTR_WR_EN,
  input wire logic [3:0] PTR_RD_SEL,
  input wire logic ADDR_VALID,
  input wire logic [22:0] ADDR_FIRST,
  input wire logic [22:0] ADDR_SECOND,
  input wire logic ADDR_DOUBLE,
  input wire logic [4:0] DEST_FIRST,
  input wire logic [4:0] DEST_SECOND,
  input wire logic BUS_ERROR_IRQ,
  input wire logic OP_REFUSED,
  input wire logic [15:0] PTR_RD_LOW
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_cp(logic [2:0] m);
    !RST && OP_VALID && OP_MODE == m && !OP_BYTE && !PTR_WR_EN &&
    PTR_RD_SEL == MIA_SEL_COEF ##1 !PTR_WR_EN && PTR_RD_SEL == MIA_SEL_COEF;
  endsequence
  chk_post_inc: assert property (s_cp(3'h3) |=>
    PTR_RD_LOW == 16'($past(PTR_RD_LOW) + ($past(OP_DOUBLE, 2)
    ? MIA_STEP_DBL : MIA_STEP_WORD))) else $error("post increment step");
  chk_post_dec: assert property (s_cp(3'h4) |=>
    PTR_RD_LOW == 16'($past(PTR_RD_LOW) - ($past(OP_DOUBLE, 2)
    ? MIA_STEP_DBL : MIA_STEP_WORD))) else $error("post decrement step");
  chk_plain_keep: assert property (s_cp(3'h2) |=>
    $stable(PTR_RD_LOW)) else $error("plain mode moved pointer");
  chk_short_zero: assert property (!RST && OP_VALID &&
    OP_MODE == 3'h1 && OP_SHORT_OFFSET == 3'h0 |=> OP_REFUSED && !ADDR_VALID)
    else $error("zero short offset accepted");
  chk_long_par: assert property (!RST && OP_VALID && OP_PARALLEL &&
    OP_MODE inside {3'h0, 3'h5, 3'h6} |=> OP_REFUSED && !ADDR_VALID)
    else $error("parallel long offset accepted");
  chk_pair_addr: assert property (ADDR_VALID && ADDR_DOUBLE |->
    ADDR_SECOND == (ADDR_FIRST[0] ? ADDR_FIRST - MIA_PAIR_STEP
    : ADDR_FIRST + MIA_PAIR_STEP)) else $error("pair address wrong");
  chk_pair_dest: assert property (ADDR_VALID && ADDR_DOUBLE |->
    DEST_SECOND == 5'(DEST_FIRST + MIA_DEST_STEP))
    else $error("pair destination wrong");
  chk_irq_cause: assert property (BUS_ERROR_IRQ |->
    $past(OP_VALID && OP_BYTE && !OP_DOUBLE) && !ADDR_VALID && !OP_REFUSED)
    else $error("bus error without byte form");
  chk_byte_pair: assert property (!RST && OP_VALID &&
    OP_BYTE && OP_DOUBLE |=> OP_REFUSED) else $error("byte pair accepted");
  chk_one_answer: assert property (!RST && OP_VALID |=>
    $onehot({ADDR_VALID, OP_REFUSED, BUS_ERROR_IRQ}))
    else $error("not exactly one answer");
  cover property (ADDR_VALID && ADDR_DOUBLE);
  cover property (BUS_ERROR_IRQ);
  cover property (OP_REFUSED);
endmodule : mia_properties

bind mmr_indirect_address_gen mia_properties u_props (.MCLK, .RST,
  .OP_VALID, .OP_MODE, .OP_DOUBLE, .OP_BYTE, .OP_PARALLEL, .OP_SHORT_OFFSET,
  .PTR_WR_EN, .PTR_RD_SEL, .ADDR_VALID, .ADDR_FIRST, .ADDR_SECOND,
  .ADDR_DOUBLE, .DEST_FIRST, .DEST_SECOND, .BUS_ERROR_IRQ, .OP_REFUSED,
  .PTR_RD_LOW);

//--- sim/mmr_indirect_address_gen_tb_top.sv
// Self-checking bench of the indirect operand address generator.
`timescale 1ns/10ps
module mmr_indirect_address_gen_tb_top
  import mia_pkg::*;
;
  logic MCLK = 1'b0, RST = 1'b1, OP_VALID = 1'b0, OP_DOUBLE = 1'b0;
  logic OP_BYTE = 1'b0, OP_PARALLEL = 1'b0, PTR_WR_EN = 1'b0;
  logic [2:0] OP_MODE = 3'h0, OP_AUX_SEL = 3'h0, OP_SHORT_OFFSET = 3'h1;
  logic [15:0] OP_LONG_OFFSET = 16'h0, COEF_BUFFER_START = 16'h0;
  logic [15:0] PTR_WR_LOW = 16'h0;
  logic [4:0] OP_DEST = 5'h0, DEST_FIRST, DEST_SECOND;
  logic [8:0] CIRC_CONFIG = 9'h0, cmask = 9'h1FF;
  logic [3:0] PTR_WR_SEL = 4'h0, PTR_RD_SEL = 4'h8;
  logic [6:0] PTR_WR_HIGH = 7'h0, PTR_RD_HIGH;
  logic ADDR_VALID, ADDR_DOUBLE, BUS_ERROR_IRQ, OP_REFUSED;
  logic [22:0] ADDR_FIRST, ADDR_SECOND;
  logic [15:0] PTR_RD_LOW, plo [9];
  wire logic [15:0] AUX_BUFFER_START;
  logic [6:0] phi [9];
  logic [59:0] expq [$], g, e;
  logic [31:0] seed = 32'hF2EE9F95;
  int n_mismatch = 0, compares = 0;

  mmr_indirect_address_gen u_dut (.MCLK, .RST, .OP_VALID, .OP_MODE,
    .OP_AUX_SEL, .OP_DOUBLE, .OP_BYTE, .OP_PARALLEL, .OP_LONG_OFFSET,
    .OP_SHORT_OFFSET, .OP_DEST, .CIRC_CONFIG, .AUX_BUFFER_START,
    .COEF_BUFFER_START, .PTR_WR_EN, .PTR_WR_SEL, .PTR_WR_LOW, .PTR_WR_HIGH,
    .PTR_RD_SEL, .ADDR_VALID, .ADDR_FIRST, .ADDR_SECOND, .ADDR_DOUBLE,
    .DEST_FIRST, .DEST_SECOND, .BUS_ERROR_IRQ, .OP_REFUSED, .PTR_RD_LOW,
    .PTR_RD_HIGH);
  mia_decoder_model u_dec (.aux_sel(OP_AUX_SEL), .aux_start(AUX_BUFFER_START));

  initial
  begin
    forever #12.5 MCLK = ~MCLK;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  task chk(input logic [59:0] got, input logic [59:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task wr(input logic [3:0] i, input logic [15:0] lo, input logic [6:0] hi);
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    PTR_WR_EN <= 1'b1;
    PTR_WR_SEL <= i;
    PTR_WR_LOW <= lo;
    PTR_WR_HIGH <= hi;
    plo[i] = lo;
    phi[i] = hi;
  endtask : wr

  task op(input logic [2:0] m, a, input logic d, b, p,
    input logic [15:0] k, input logic [2:0] s, input logic [4:0] r);
    logic [3:0] i;
    logic [15:0] st, np, cs;
    logic [22:0] ad;
    logic [8:0] cf;
    i = (m < 3'h2) ? {1'b0, a} : 4'h8;
    cf = 9'(rnd()) & cmask;
    cs = 16'(rnd());
    st = cf[i] ? ((m < 3'h2) ? {1'h0, a, 12'h300} : cs) : 16'h0;
    np = plo[i];
    if (m == 3'h0 || m == 3'h6)
      np = np + k;
    if (m == 3'h3 || m == 3'h4)
      np = (m == 3'h3) ? np + (d ? 16'h2 : 16'h1) : np - (d ? 16'h2 : 16'h1);
    ad = {phi[i], 16'(st + ((m == 3'h0 || m == 3'h6) ? np : plo[i]) +
      (m == 3'h1 ? {13'h0, s} : (m == 3'h5 ? k : 16'h0)))};
    @(posedge MCLK);
    PTR_WR_EN <= 1'b0;
    OP_VALID <= 1'b1;
    OP_MODE <= m;
    OP_AUX_SEL <= a;
    OP_DOUBLE <= d;
    OP_BYTE <= b;
    OP_PARALLEL <= p;
    OP_LONG_OFFSET <= k;
    OP_SHORT_OFFSET <= s;
    OP_DEST <= r;
    CIRC_CONFIG <= cf;
    COEF_BUFFER_START <= cs;
    if (m == 3'h7 || (m == 3'h1 && s == 3'h0) || (b && d) ||
      (p && (m == 3'h0 || m >= 3'h5)))
      expq.push_back({3'b010, 57'h0});
    else if (b && ad <= MIA_MAPPED_TOP_DEFAULT)
      expq.push_back({3'b100, 57'h0});
    else
    begin
      expq.push_back({3'b001, ad, d ? (ad[0] ? ad - 23'h1 : ad + 23'h1) : ad,
        d, r, d ? 5'(r + 5'h1) : r});
      plo[i] = np;
    end
  endtask : op

  task idle(input string nm);
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    PTR_WR_EN <= 1'b0;
    repeat (4) @(posedge MCLK);
    $display("test %0s done", nm);
  endtask : idle

  always @(posedge MCLK)
    if (!RST && (ADDR_VALID || OP_REFUSED || BUS_ERROR_IRQ))
    begin
      e = (expq.size() > 0) ? expq.pop_front() : 60'h0;
      g = {BUS_ERROR_IRQ, OP_REFUSED, ADDR_VALID, ADDR_FIRST, ADDR_SECOND,
        ADDR_DOUBLE, DEST_FIRST, DEST_SECOND};
      if (!e[57])
        g[56:0] = 57'h0;
      chk(g, e);
    end

  initial
  begin
    repeat (3000) @(posedge MCLK);
    n_mismatch++;
    wrap_up;
  end

  initial
  begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    chk(60'({ADDR_VALID, ADDR_FIRST, PTR_RD_LOW}), 60'h0);
    for (int k = 0; k < 9; k++)
      wr(4'(k), 16'(rnd()), 7'(7'h10 + k));
    idle("load");
    repeat (80) op(3'(rnd() % 7), 3'(rnd()), 1'(rnd()), 1'b0, 1'b0,
      16'(rnd()), 3'(rnd() % 7 + 1), 5'(rnd()));
    idle("modes");
    wr(4'h8, 16'hFFFF, 7'h05);
    op(3'h3, 3'h0, 1'b1, 1'b0, 1'b0, 16'h0, 3'h1, 5'h1F);
    op(3'h4, 3'h0, 1'b1, 1'b0, 1'b0, 16'h0, 3'h1, 5'h03);
    op(3'h4, 3'h0, 1'b0, 1'b0, 1'b0, 16'h0, 3'h1, 5'h04);
    idle("wrap");
    op(3'h7, 3'h1, 1'b0, 1'b0, 1'b0, 16'h0, 3'h1, 5'h0);
    op(3'h1, 3'h2, 1'b0, 1'b0, 1'b0, 16'h0, 3'h0, 5'h0);
    op(3'h1, 3'h2, 1'b1, 1'b0, 1'b1, 16'h0, 3'h7, 5'h6);
    for (int m = 0; m < 7; m++)
      op(3'(m), 3'h5, 1'b0, 1'b0, 1'b1, 16'h0010, 3'h2, 5'h2);
    op(3'h2, 3'h0, 1'b1, 1'b1, 1'b0, 16'h0, 3'h1, 5'h0);
    idle("refuse");
    cmask = 9'h0;
    wr(4'h8, 16'h0003, 7'h00);
    for (int m = 2; m < 7; m++)
      op(3'(m), 3'h0, 1'b0, 1'b1, 1'b0, 16'h0004, 3'h1, 5'h1);
    op(3'h1, 3'h2, 1'b0, 1'b1, 1'b0, 16'h0, 3'h1, 5'h0);
    wr(4'h8, 16'h005F, 7'h00);
    op(3'h2, 3'h0, 1'b0, 1'b1, 1'b0, 16'h0, 3'h1, 5'h0);
    wr(4'h8, 16'h0060, 7'h00);
    op(3'h2, 3'h0, 1'b0, 1'b1, 1'b0, 16'h0, 3'h1, 5'h0);
    idle("byte");
    for (int k = 0; k < 9; k++)
    begin
      PTR_RD_SEL <= 4'(k);
      repeat (3) @(posedge MCLK);
      chk(60'({PTR_RD_HIGH, PTR_RD_LOW}), 60'({phi[k], plo[k]}));
    end
    PTR_RD_SEL <= 4'h8;
    idle("readback");
    chk(60'(expq.size()), 60'h0);
    wrap_up;
  end
endmodule : mmr_indirect_address_gen_tb_top
